/* dcoc_pkg.sv */
// Purpose: Constants and types for the display clock output controller.
// Assumes: 8-bit internal register bus, one system clock.
// Notes: Source code and gating fields live in two byte registers.
//
// Behaviour
// - The 4-bit source code in bits 0 to 3 picks peripheral/64 (0110), peripheral/128 (0111) or subsystem clock (1000); other codes are prohibited.
// - The display clock runs only while clock_out_enable is 1 and pin_direction_bit is 0.
// - Reset clears the clock selection register to zero.
// - Reset sets every bit of the port mode register to one.
// - The clock selection register sits at FF40H and takes bit and byte writes.
// - Enabling or disabling never produces a shortened high or low pulse.
// - Output starts in the low phase and stops only after a full high level.
package dcoc_pkg;

    // ========================================
    // Register map
    localparam logic [15:0] DCOC_ADDR_SELECT = 16'hFF40;
    localparam logic [15:0] DCOC_ADDR_PORT14 = 16'hFF2E;
    localparam logic [7:0] DCOC_SELECT_RESET = 8'h00;
    localparam logic [7:0] DCOC_PORT14_RESET = 8'hFF;
    localparam logic [7:0] DCOC_SELECT_MASK = 8'h1F;

    // ========================================
    // Field positions
    localparam int DCOC_ENABLE_BIT = 4;
    localparam int DCOC_PIN_DIR_BIT = 0;

    // ========================================
    // Source codes
    localparam logic [3:0] DCOC_SRC_DIV64 = 4'h6;
    localparam logic [3:0] DCOC_SRC_DIV128 = 4'h7;
    localparam logic [3:0] DCOC_SRC_SUB = 4'h8;
    localparam int DCOC_DIV_WIDTH = 7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } dcoc_bus_t;

    typedef enum logic [2:0] {
        DCOC_OFF = 3'b001,
        DCOC_RUN = 3'b010,
        DCOC_STOP = 3'b100
    } dcoc_state_t;

endpackage

/* dcoc_sync.sv */
// Purpose: Two-flop synchroniser for the subsystem clock level.
// Assumes: Input is asynchronous to clk_sys.
// Notes: The first flop feeds only the second.
`timescale 1ns/10ps
`default_nettype none
module dcoc_sync (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Data
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* dcoc_top.sv */
// Purpose: Display clock source select and glitch-free gating.
// Assumes: Peripheral clock is clk_sys; subsystem clock is an input level.
// Notes: The subsystem level is sampled, so it must be far below clk_sys.
`timescale 1ns/10ps
`default_nettype none
module dcoc_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register bus
    input wire dcoc_pkg::dcoc_bus_t bus_in,
    output logic [7:0] bus_rdata,
    // Clock sources
    input wire logic subsystem_clock,
    // Display controller side
    output logic display_clock_output,
    output logic display_clock_active
);
    import dcoc_pkg::*;

    logic [7:0] display_clock_select_q;
    logic [7:0] port14_direction_q;
    logic [DCOC_DIV_WIDTH-1:0] div_q;
    logic sub_sync;
    logic src_level;
    logic src_level_q;
    logic gate_open;
    logic out_q;
    dcoc_state_t state_q;
    logic [3:0] src_code;
    logic clock_out_enable;
    logic pin_direction_bit;
    logic sel_hit;
    logic port_hit;

    // One decode serves the write and read paths of both registers.
    function automatic logic addr_hit(input logic [15:0] addr,
            input logic [15:0] base);
        return addr == base;
    endfunction

    assign src_code = display_clock_select_q[3:0];
    assign clock_out_enable = display_clock_select_q[DCOC_ENABLE_BIT];
    assign pin_direction_bit = port14_direction_q[DCOC_PIN_DIR_BIT];
    assign gate_open = clock_out_enable && !pin_direction_bit;
    assign sel_hit = addr_hit(bus_in.addr, DCOC_ADDR_SELECT);
    assign port_hit = addr_hit(bus_in.addr, DCOC_ADDR_PORT14);

    // ========================================
    // Registers
    // Both bit and byte writes arrive as whole-byte writes of the merged
    // value, so one write path serves both. Upper bits of the select register are forced to zero.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            display_clock_select_q <= DCOC_SELECT_RESET;
        end else if (bus_in.wr && sel_hit) begin
            // Bits 7 to 5 always read back as zero, whatever is written.
            display_clock_select_q <= bus_in.wdata & DCOC_SELECT_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port14_direction_q <= DCOC_PORT14_RESET;
        end else if (bus_in.wr && port_hit) begin
            port14_direction_q <= bus_in.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            bus_rdata <= 8'h00;
        end else if (bus_in.rd) begin
            if (sel_hit) begin
                bus_rdata <= display_clock_select_q;
            end else if (port_hit) begin
                bus_rdata <= port14_direction_q;
            end else begin
                bus_rdata <= 8'h00;
            end
        end
    end

    // ========================================
    // Source generation
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + DCOC_DIV_WIDTH'(1);
        end
    end

    dcoc_sync u_sub_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(subsystem_clock),
        .sync_out(sub_sync)
    );

    // Prohibited codes select a constant low so nothing toggles.
    always_comb begin
        unique case (src_code)
            DCOC_SRC_DIV64: src_level = div_q[5];
            DCOC_SRC_DIV128: src_level = div_q[6];
            DCOC_SRC_SUB: src_level = sub_sync;
            default: src_level = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            src_level_q <= 1'b0;
        end else begin
            src_level_q <= src_level;
        end
    end

    // ========================================
    // Glitch-free gate
    // Start only in a low phase, stop only in a low phase of the source, so the last
    // high is always full length and no runt low appears at start.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= DCOC_OFF;
        end else begin
            unique case (state_q)
                DCOC_OFF: begin
                    if (gate_open && !src_level) begin
                        state_q <= DCOC_RUN;
                    end
                end
                DCOC_RUN: begin
                    if (!gate_open) begin
                        state_q <= DCOC_STOP;
                    end
                end
                DCOC_STOP: begin
                    if (!src_level) begin
                        state_q <= gate_open ? DCOC_RUN : DCOC_OFF;
                    end
                end
                default: state_q <= DCOC_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_q <= 1'b0;
        end else if (state_q == DCOC_OFF) begin
            out_q <= 1'b0;
        end else if (state_q == DCOC_STOP && !src_level) begin
            out_q <= 1'b0;
        end else begin
            out_q <= src_level;
        end
    end

    assign display_clock_output = out_q;
    assign display_clock_active = (state_q != DCOC_OFF);

endmodule
`default_nettype wire

/* dcoc_sva.sv */
// Purpose: Port checks for the display clock controller.
// Assumes: Every source phase lasts at least 8 clk_sys cycles.
// Notes: Bound to dcoc_top below the module.
`timescale 1ns/10ps
`default_nettype none
module dcoc_sva import dcoc_pkg::*; (
    // Watched ports
    input wire logic clk_sys,
    input wire logic reset,
    input wire dcoc_pkg::dcoc_bus_t bus_in,
    input wire logic [7:0] bus_rdata,
    input wire logic subsystem_clock,
    input wire logic display_clock_output,
    input wire logic display_clock_active
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> bus_rdata == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("reset rdata");
    property p_idle;
        !display_clock_active [*2] |-> !display_clock_output;
    endproperty
    a_idle: assert property (p_idle) else $error("idle high");
    property p_mask;
        bus_in.rd && bus_in.addr == DCOC_ADDR_SELECT |=> !bus_rdata[7:5];
    endproperty
    a_mask: assert property (p_mask) else $error("upper bits");
    property p_unmap; bus_in.rd && bus_in.addr == 16'hFF41
        |=> bus_rdata == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped");
    property p_high;
        $rose(display_clock_output) |-> display_clock_output [*8];
    endproperty
    a_high: assert property (p_high) else $error("short high");
    property p_low;
        $fell(display_clock_output) |-> !display_clock_output [*8];
    endproperty
    a_low: assert property (p_low) else $error("short low");
    property p_start;
        $rose(display_clock_active) |-> !display_clock_output;
    endproperty
    a_start: assert property (p_start) else $error("start high");
    property p_pin; bus_in.wr && bus_in.addr == DCOC_ADDR_PORT14 &&
        bus_in.wdata[0] |-> ##[1:100] !display_clock_active; endproperty
    a_pin: assert property (p_pin) else $error("pin no stop");
endmodule
bind dcoc_top dcoc_sva u_sva (
    .clk_sys(clk_sys),
    .reset(reset),
    .bus_in(bus_in),
    .bus_rdata(bus_rdata),
    .subsystem_clock(subsystem_clock),
    .display_clock_output(display_clock_output),
    .display_clock_active(display_clock_active)
);
`default_nettype wire

/* dcoc_lcd_model.sv */
// Purpose: Display controller clock input that measures run lengths.
// Assumes: Sampled on clk_sys.
// Notes: The idle low run before enable counts as a long run.
`timescale 1ns/10ps
`default_nettype none
module dcoc_lcd_model (
    // Clock and observed input
    input wire logic clk_sys,
    input wire logic lcd_clk,
    // Measurements
    output int pulses,
    output int last_high,
    output int min_run
);
    logic prev = 1'b0;
    logic level;
    int run = 0;
    // An unknown level before reset counts as low, not as an edge.
    assign level = (lcd_clk === 1'b1);
    initial pulses = 0;
    initial min_run = 1000;
    // A short run in either level would be taken as a glitch.
    always @(posedge clk_sys) begin
        prev <= level;
        run <= (level == prev) ? run + 1 : 1;
        if (level != prev && run < min_run) min_run <= run;
        if (level != prev && prev) begin
            last_high <= run;
            pulses <= pulses + 1;
        end
    end
endmodule
`default_nettype wire

/* display_clock_output_ctrl_bench.sv */
// Purpose: Self-checking bench for dcoc_top.
// Assumes: Subsystem clock phase is 10 clk_sys cycles.
// Notes: Each source is started, measured and stopped by the pin bit.
`timescale 1ns/10ps
`default_nettype none
module display_clock_output_ctrl_bench;
    import dcoc_pkg::*;
    logic clk_sys = 0, reset = 1, subsystem_clock = 0;
    dcoc_bus_t bus_in = '0;
    logic [7:0] bus_rdata;
    logic display_clock_output, display_clock_active;
    int err_count = 0, comparisons = 0, pulses, last_high, min_run, n, p0;
    initial forever #10 clk_sys = ~clk_sys;
    initial #3 forever #200 subsystem_clock = ~subsystem_clock;
    dcoc_top u_dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .bus_in(bus_in),
        .bus_rdata(bus_rdata),
        .subsystem_clock(subsystem_clock),
        .display_clock_output(display_clock_output),
        .display_clock_active(display_clock_active)
    );
    dcoc_lcd_model u_lcd (.clk_sys(clk_sys), .lcd_clk(display_clock_output),
        .pulses(pulses), .last_high(last_high), .min_run(min_run));
    task check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task give_up;
        err_count++;
        complete_run();
    endtask
    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys) bus_in <= '{1'b1, 1'b0, a, d};
        @(posedge clk_sys) bus_in <= '0;
    endtask
    task rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys) bus_in <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys) bus_in <= '0;
        #1 check(bus_rdata, e);
    endtask
    // Runs one source; the pin bit stops it, so both gates are exercised.
    task run_src(input logic [3:0] code, input logic [7:0] high);
        wr(DCOC_ADDR_PORT14, 8'hFC);
        wr(DCOC_ADDR_SELECT, {4'h0, code});
        wr(DCOC_ADDR_SELECT, {4'h1, code});
        p0 = pulses;
        for (n = 0; n < 3000 && pulses < p0 + 3; n++) @(posedge clk_sys);
        if (n == 3000) give_up();
        check(8'(last_high), high);
        wr(DCOC_ADDR_PORT14, 8'hFD);
        for (n = 0; n < 200 && display_clock_active !== 1'b0; n++)
            @(posedge clk_sys);
        if (n == 200) give_up();
        check({7'h0, display_clock_output}, 8'h00);
        wr(DCOC_ADDR_SELECT, {4'h0, code});
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(DCOC_ADDR_SELECT, 8'h00);
        rd(DCOC_ADDR_PORT14, 8'hFF);
        rd(16'hFF41, 8'h00);
        wr(DCOC_ADDR_SELECT, 8'h06);
        wr(DCOC_ADDR_SELECT, 8'h16);
        rd(DCOC_ADDR_SELECT, 8'h16);
        check({7'h0, display_clock_active}, 8'h00);
        wr(DCOC_ADDR_SELECT, 8'h06);
        run_src(DCOC_SRC_DIV64, 8'd32);
        run_src(DCOC_SRC_DIV128, 8'd64);
        run_src(DCOC_SRC_SUB, 8'd10);
        p0 = pulses;
        wr(DCOC_ADDR_SELECT, 8'h03);
        wr(DCOC_ADDR_SELECT, 8'h13);
        wr(DCOC_ADDR_PORT14, 8'hFC);
        repeat (300) @(posedge clk_sys);
        check(8'(pulses - p0), 8'h00);
        check(8'(min_run >= 10), 8'h01);
        complete_run();
    end
endmodule
`default_nettype wire
